// [include/pa_params.svh]
/*
 * Constants of the pulse accumulator and periodic interrupt block: register
 * indices, field positions, reset values and timing figures.
 * Assumes it is included by bare name from the package and the design file.
 */
// How it works
// RL1 - Writing ones to the flag register clears those flags; zeros leave flags alone.
// RL2 - Main overflow flag sets when the 16-bit main counter wraps to zero.
// RL3 - Periodic flag, bit 6, sets each interval end; cleared by writing bit 6.
// RL4 - Flag register bits 3 to 0 always read zero.
// RL5 - Periodic timebase is E divided by 2^13, independent of any prescaler.
// RL6 - Accumulator enable bit: 0 disables, 1 enables the accumulator.
// RL7 - Accumulator mode bit: 0 counts events, 1 accumulates gated time.
// RL8 - Outside source keeps event pin toggling no faster than half E rate.
// RL9 - Gated mode counts E/64 ticks only while the pin is at its active level.
// RL10 - Event mode: edge select 0 counts falling edges, 1 counts rising edges.
// RL11 - Gated mode: edge select 0 inhibits on low pin, 1 inhibits on high.
// RL12 - Select bit 0 enables compare five, 1 enables capture four, never both.
// RL13 - Count register is readable and writable anytime and untouched by reset.
// RL14 - Increments occur on the E phase, apart from register read sampling.
// RL15 - Accumulator overflow flag, bit 5, sets on FF to 00 rollover; write-one clears.
// RL16 - Overflow enable raises a request when the flag sets; never alters the flag.
// RL17 - Input edge flag, bit 4, sets on each selected edge; write-one clears.
// RL18 - Edge enable raises a request when the flag sets; flag itself unaffected.
// RL19 - Service software clears the serviced flag before returning.
// RL20 - Each flag pairs with the mask bit in the same high position.
// RL21 - Rate bits 00 to 11 select E divided by 2^13, 2^14, 2^15, 2^16.
// RL22 - Timebase stops only at reset; intervals chain; first flag one interval after reset.
// RL23 - Periodic enable at 1 raises a request while the periodic flag is set.
// RL24 - Main overflow enable gates its request; at 0 the request is suppressed.
// RL25 - While disabled the count holds and pin activity sets no flag.
`ifndef PA_PARAMS_SVH
`define PA_PARAMS_SVH

`define PA_IDX_MASKS 16'h1024
`define PA_IDX_FLAGS 16'h1025
`define PA_IDX_CTRL 16'h1026
`define PA_IDX_COUNT 16'h1027

`define PA_CTRL_EN_BIT 6
`define PA_CTRL_MODE_BIT 5
`define PA_CTRL_EDGE_BIT 4
`define PA_CTRL_CCSEL_BIT 2
`define PA_CTRL_RATE_LSB 0
`define PA_FLAGS_LSB 4
`define PA_PRESCALE_LSB 0

`define PA_CTRL_RST 6'h00
`define PA_FLAGS_RST 4'h0
`define PA_MASKS_RST 4'h0
`define PA_PRESCALE_RST 2'h0

`define PA_MCLK_HZ 50000000
`define PA_E_HZ 2000000
`define PA_E_DIV (`PA_MCLK_HZ / `PA_E_HZ)
`define PA_RTI_BASE_EXP 13
`define PA_GATE_DIV 64

`define PA_RESP_OKAY 2'h0
`define PA_RESP_SLVERR 2'h2

`endif

// [include/pa_pkg.sv]
/*
 * Types of the pulse accumulator and periodic interrupt block.
 * Assumes pa_params.svh is on the include path.
 */
`include "pa_params.svh"

package pa_pkg;

    // Control fields, in register order with the port A bits removed.
    typedef struct packed {
        logic accumulator_enable;
        logic accumulator_mode;
        logic edge_level_sel;
        logic capture_compare_sel;
        logic [1:0] periodic_rate_sel;
    } pa_ctrl_t;

    // Four flags, or the four enables that pair with them, high bit first.
    typedef struct packed {
        logic main_overflow;
        logic periodic;
        logic accum_overflow;
        logic input_edge;
    } pa_flags_t;

endpackage

// [rtl/pa_top.sv]
/*
 * Pulse accumulator, periodic interrupt timebase, main counter overflow flag
 * and second flag and mask registers, reached over an AXI4-Lite slave.
 * Assumes one clock mclk, an asynchronous active-high reset and a pin input
 * that is already synchronous to mclk.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pa_params.svh"

module pa_top #(
    parameter int AW = 16,
    parameter int E_DIV = `PA_E_DIV,
    parameter int RTI_BASE_EXP = `PA_RTI_BASE_EXP,
    parameter int GATE_DIV = `PA_GATE_DIV,
    parameter int MAIN_W = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write address and data.
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Accumulator pin.
    input wire logic accumulator_input_pin,
    // Interrupt requests and capture/compare steering.
    output pa_pkg::pa_flags_t irq_sources,
    output logic irq,
    output logic input_capture_four,
    output logic output_compare_five
);
    import pa_pkg::*;

    localparam int IW = AW - 2;
    localparam int EW = $clog2(E_DIV + 1);
    localparam int GW = $clog2(GATE_DIV);
    localparam logic [IW-1:0] IDX_MASKS = IW'(`PA_IDX_MASKS);
    localparam logic [IW-1:0] IDX_FLAGS = IW'(`PA_IDX_FLAGS);
    localparam logic [IW-1:0] IDX_CTRL = IW'(`PA_IDX_CTRL);
    localparam logic [IW-1:0] IDX_COUNT = IW'(`PA_IDX_COUNT);

    pa_ctrl_t ctrl;
    pa_flags_t flags;
    pa_flags_t masks;
    logic [1:0] prescale;
    logic [7:0] accumulator_count;
    logic [MAIN_W-1:0] main_counter;
    logic [15:0] rti_count;
    logic [15:0] rti_mask;
    logic [EW-1:0] e_div_count;
    logic [GW-1:0] gate_div;
    logic e_tick;
    logic pin_q;
    logic aw_full;
    logic w_full;
    logic [IW-1:0] aw_idx;
    logic aw_ok;
    logic [7:0] wbyte;
    logic wlane;
    logic wr_go;
    logic wr_flags;
    logic wr_masks;
    logic wr_ctrl;
    logic wr_count;
    logic [IW-1:0] ar_idx;
    logic ar_ok;
    logic [31:0] rd_word;
    logic rise;
    logic fall;
    logic sel_edge;
    logic gate_tick;
    logic gate_open;
    logic gate_end;
    logic count_inc;
    logic rti_timeout;
    logic main_wrap;
    pa_flags_t set_ev;
    pa_flags_t clr_ev;
    logic count_seen;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // E clock enable: every count of the accumulator happens on this phase,
    // so a bus read that lands between ticks never sees a half-updated count.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            e_div_count <= '0;
            e_tick <= 1'b0;
        end
        else if (e_div_count == EW'(E_DIV - 1))
        begin
            e_div_count <= '0;
            e_tick <= 1'b1; // see RL14
        end
        else
        begin
            e_div_count <= e_div_count + 1'b1;
            e_tick <= 1'b0;
        end
    end

    // Write channel: address and data are taken in either order, then the
    // response follows both; one write outstanding at a time.
    assign wr_go = aw_full && w_full && !s_axi_bvalid;
    assign wr_flags = wr_go && aw_ok && wlane && aw_idx == IDX_FLAGS;
    assign wr_masks = wr_go && aw_ok && wlane && aw_idx == IDX_MASKS;
    assign wr_ctrl = wr_go && aw_ok && wlane && aw_idx == IDX_CTRL;
    assign wr_count = wr_go && aw_ok && wlane && aw_idx == IDX_COUNT;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_idx <= '0;
            aw_ok <= 1'b0;
            wbyte <= 8'h00;
            wlane <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PA_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full <= 1'b1;
                s_axi_awready <= 1'b0;
                aw_idx <= s_axi_awaddr[AW-1:2];
                aw_ok <= s_axi_awaddr[1:0] == 2'h0 && (s_axi_awaddr[AW-1:2] == IDX_MASKS ||
                    s_axi_awaddr[AW-1:2] == IDX_FLAGS || s_axi_awaddr[AW-1:2] == IDX_CTRL ||
                    s_axi_awaddr[AW-1:2] == IDX_COUNT);
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full <= 1'b1;
                s_axi_wready <= 1'b0;
                wbyte <= s_axi_wdata[7:0];
                wlane <= s_axi_wstrb[0];
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_ok ? `PA_RESP_OKAY : `PA_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read mux; unimplemented and port A bits read as zero.
    assign ar_idx = s_axi_araddr[AW-1:2];
    always_comb
    begin
        ar_ok = s_axi_araddr[1:0] == 2'h0;
        rd_word = 32'h0000_0000;
        if (ar_idx == IDX_FLAGS)
        begin
            rd_word[`PA_FLAGS_LSB +: 4] = flags; // see RL4
        end
        else if (ar_idx == IDX_MASKS)
        begin
            rd_word[`PA_FLAGS_LSB +: 4] = masks;
            rd_word[`PA_PRESCALE_LSB +: 2] = prescale;
        end
        else if (ar_idx == IDX_CTRL)
        begin
            rd_word[`PA_CTRL_EN_BIT] = ctrl.accumulator_enable;
            rd_word[`PA_CTRL_MODE_BIT] = ctrl.accumulator_mode;
            rd_word[`PA_CTRL_EDGE_BIT] = ctrl.edge_level_sel;
            rd_word[`PA_CTRL_CCSEL_BIT] = ctrl.capture_compare_sel;
            rd_word[`PA_CTRL_RATE_LSB +: 2] = ctrl.periodic_rate_sel;
        end
        else if (ar_idx == IDX_COUNT)
        begin
            rd_word[7:0] = accumulator_count; // see RL13
        end
        else
        begin
            ar_ok = 1'b0;
        end
        if (!ar_ok)
        begin
            rd_word = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PA_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= ar_ok ? `PA_RESP_OKAY : `PA_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Control and mask registers.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `PA_CTRL_RST;
            masks <= `PA_MASKS_RST;
            prescale <= `PA_PRESCALE_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ctrl.accumulator_enable <= wbyte[`PA_CTRL_EN_BIT]; // see RL6
                ctrl.accumulator_mode <= wbyte[`PA_CTRL_MODE_BIT]; // see RL7
                ctrl.edge_level_sel <= wbyte[`PA_CTRL_EDGE_BIT];
                ctrl.capture_compare_sel <= wbyte[`PA_CTRL_CCSEL_BIT];
                ctrl.periodic_rate_sel <= wbyte[`PA_CTRL_RATE_LSB +: 2];
            end
            if (wr_masks)
            begin
                masks <= wbyte[`PA_FLAGS_LSB +: 4];
                prescale <= wbyte[`PA_PRESCALE_LSB +: 2];
            end
        end
    end

    // Pin sampled on the E phase; edges are seen at most once per E cycle,
    // which is why the source must stay below half the E rate.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pin_q <= 1'b0;
        end
        else if (e_tick)
        begin
            pin_q <= accumulator_input_pin; // see RL8
        end
    end

    assign rise = e_tick && accumulator_input_pin && !pin_q;
    assign fall = e_tick && !accumulator_input_pin && pin_q;
    assign sel_edge = ctrl.edge_level_sel ? rise : fall; // see RL10

    // Free-running E/64 divider for gated accumulation.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            gate_div <= '0;
        end
        else if (e_tick)
        begin
            gate_div <= gate_div + 1'b1;
        end
    end

    assign gate_tick = e_tick && gate_div == GW'(GATE_DIV - 1); // see RL9
    assign gate_open = pin_q != ctrl.edge_level_sel; // see RL11
    assign gate_end = (rise || fall) && accumulator_input_pin == ctrl.edge_level_sel;

    always_comb
    begin
        count_inc = 1'b0;
        if (ctrl.accumulator_enable) // see RL25
        begin
            if (ctrl.accumulator_mode)
            begin
                count_inc = gate_tick && gate_open; // see RL9
            end
            else
            begin
                count_inc = sel_edge; // see RL10
            end
        end
    end

    // The count has no reset; a software write wins over a same-cycle count.
    always_ff @(posedge mclk)
    begin
        if (wr_count)
        begin
            accumulator_count <= wbyte; // see RL13
        end
        else if (count_inc)
        begin
            accumulator_count <= accumulator_count + 8'h01; // see RL14
        end
    end

    // Main counter, prescale of one; only its wrap is used here.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            main_counter <= '0;
        end
        else if (e_tick)
        begin
            main_counter <= main_counter + 1'b1;
        end
    end

    assign main_wrap = e_tick && main_counter == '1; // see RL2

    // Periodic timebase: free-running from reset, never cleared by software.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rti_count <= 16'h0000; // see RL22
        end
        else if (e_tick)
        begin
            rti_count <= rti_count + 16'h0001;
        end
    end

    assign rti_mask = 16'hFFFF >> (5'd16 - 5'(RTI_BASE_EXP) - 5'(ctrl.periodic_rate_sel)); // see RL21
    assign rti_timeout = e_tick && (rti_count & rti_mask) == rti_mask; // see RL5

    // Flag set and clear; a set in the clearing cycle wins.
    always_comb
    begin
        set_ev.main_overflow = main_wrap;
        set_ev.periodic = rti_timeout; // see RL3
        set_ev.accum_overflow = count_inc && !wr_count && accumulator_count == 8'hFF; // see RL15
        set_ev.input_edge = ctrl.accumulator_enable && (ctrl.accumulator_mode ? gate_end : sel_edge); // see RL17
        clr_ev = wr_flags ? pa_flags_t'(wbyte[`PA_FLAGS_LSB +: 4]) : `PA_FLAGS_RST; // see RL1
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flags <= `PA_FLAGS_RST;
        end
        else
        begin
            flags <= (flags & ~clr_ev) | set_ev; // see RL1
        end
    end

    // Requests pair each flag with the mask bit in the same position.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_sources <= `PA_FLAGS_RST;
            irq <= 1'b0;
            input_capture_four <= 1'b0;
            output_compare_five <= 1'b1;
        end
        else
        begin
            irq_sources <= flags & masks; // see RL20
            irq <= |(flags & masks); // see RL16, RL18, RL23, RL24
            input_capture_four <= ctrl.capture_compare_sel; // see RL12
            output_compare_five <= !ctrl.capture_compare_sel; // see RL12
        end
    end

    // The gate-inhibit and disabled-hold checks start at the first count write, since reset leaves the count unknown.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_seen <= 1'b0;
        end
        else if (wr_count)
        begin
            count_seen <= 1'b1;
        end
    end

    sequence s_clear_periodic;
        wr_flags && wbyte[`PA_FLAGS_LSB + 2] && !rti_timeout;
    endsequence

    sequence s_count_edge;
        ctrl.accumulator_enable && !ctrl.accumulator_mode && sel_edge && !wr_count;
    endsequence

    a_flag_clear: assert property (s_clear_periodic |=> !flags.periodic) // see RL1
        else $error("periodic flag not cleared by write-one");
    a_flag_keep: assert property (wr_flags && !wbyte[`PA_FLAGS_LSB + 3] && flags.main_overflow // see RL1
        |=> flags.main_overflow)
        else $error("write-zero cleared a flag");
    a_unimpl_zero: assert property (s_axi_arvalid && s_axi_arready && ar_idx == IDX_FLAGS // see RL4
        |=> s_axi_rdata[3:0] == 4'h0)
        else $error("low flag bits read nonzero");
    a_rti_sets: assert property (rti_timeout |=> flags.periodic) // see RL3
        else $error("periodic flag not set at timeout");
    a_rti_spacing: assert property (rti_timeout |=> !rti_timeout [*8]) // see RL22
        else $error("periodic timeouts too close");
    a_edge_counts: assert property (s_count_edge |=> accumulator_count == $past(accumulator_count) + 8'h01) // see RL10
        else $error("selected edge not counted");
    a_gate_inhibit: assert property (count_seen && ctrl.accumulator_mode && !gate_open && !wr_count // see RL11
        |=> $stable(accumulator_count))
        else $error("count moved while gate inhibited");
    a_disabled_hold: assert property (count_seen && !ctrl.accumulator_enable && !wr_count // see RL25
        |=> $stable(accumulator_count) && !$rose(flags.input_edge))
        else $error("disabled accumulator changed");
    a_ovf_roll: assert property (count_inc && !wr_count && accumulator_count == 8'hFF // see RL15
        |=> flags.accum_overflow && accumulator_count == 8'h00)
        else $error("rollover did not set overflow flag");
    a_irq_mask: assert property (##1 irq == |($past(flags) & $past(masks))) // see RL24
        else $error("request does not follow flag and mask");
    a_cc_excl: assert property (##1 input_capture_four != output_compare_five) // see RL12
        else $error("capture and compare both enabled");
    a_wr_resp: assert property (wr_go |=> s_axi_bvalid ##0 (s_axi_bvalid throughout (!s_axi_awready [*1]))) // see the AXI4-Lite write channel note
        else $error("write response missing");

endmodule
`default_nettype wire

// [testbench/pa_pin_source.sv]
/*
 * Partner model: drives the accumulator pin with a commanded number of level changes.
 * Assumes one mclk domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pa_pin_source #(
    parameter int HOLD = 4
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Command.
    input wire logic start,
    input wire logic [3:0] toggles,
    input wire logic [3:0] slow,
    // Pin and status.
    output logic pin,
    output logic busy
);
    logic [3:0] left;
    logic [4:0] hold_cnt;
    assign busy = (left != 4'h0) || (hold_cnt != 5'h0);
    // Each level stands at least HOLD cycles, so the pin never outruns half the E rate.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pin <= 1'b0;
            left <= 4'h0;
            hold_cnt <= 5'h0;
        end
        else if (start && !busy)
        begin
            left <= toggles;
            hold_cnt <= 5'(HOLD) + {1'b0, slow};
        end
        else if (hold_cnt != 5'h0)
            hold_cnt <= hold_cnt - 5'h1;
        else if (left != 4'h0)
        begin
            pin <= ~pin;
            left <= left - 4'h1;
            hold_cnt <= 5'(HOLD) + {1'b0, slow};
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_pulse_accumulator_rti_flags.sv]
/*
 * Self-checking bench of the accumulator and periodic flag block over AXI4-Lite.
 * Assumes pa_params.svh on the include path and the pin partner model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pa_params.svh"
module tb_pulse_accumulator_rti_flags;
    import pa_pkg::*;
    localparam int EDIV = 2;
    localparam int RTI = 3;
    localparam int GDIV = 4;
    localparam int MW = 8;
    localparam logic [15:0] A_MSK = 16'(`PA_IDX_MASKS * 4);
    localparam logic [15:0] A_FLG = 16'(`PA_IDX_FLAGS * 4);
    localparam logic [15:0] A_CTL = 16'(`PA_IDX_CTRL * 4);
    localparam logic [15:0] A_CNT = 16'(`PA_IDX_COUNT * 4);
    logic mclk = 1'b0;
    logic rst, awv, wv, bre, arv, rre, start, awr, wrdy, bv, arr, rv, ic4, oc5, irq, pin, busy;
    logic [15:0] awa, ara;
    logic [31:0] wd, rd;
    logic [3:0] ws, tog, slw;
    logic [1:0] br, rr;
    pa_flags_t srcs;
    int fail_count = 0;
    int n_tests = 0;
    always #10 mclk = ~mclk;
    pa_top #(.E_DIV(EDIV), .RTI_BASE_EXP(RTI), .GATE_DIV(GDIV), .MAIN_W(MW)) DUT (.mclk(mclk), .rst(rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .accumulator_input_pin(pin), .irq_sources(srcs), .irq(irq),
        .input_capture_four(ic4), .output_compare_five(oc5));
    pa_pin_source #(.HOLD(2 * EDIV)) u_pin (.mclk(mclk), .rst(rst), .start(start),
        .toggles(tog), .slow(slw), .pin(pin), .busy(busy));
    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t %s: got %0h want %0h", $time, msg, seen, exp);
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] resp);
        int k;
        resp = 2'h3;
        @(posedge mclk);
        awa <= a;
        wd <= {24'($urandom), d};
        ws <= {3'($urandom), 1'b1};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge mclk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wrdy)
                wv <= 1'b0;
            if (bv)
            begin
                resp = br;
                bre <= 1'b0;
                break;
            end
        end
    endtask
    task automatic bus_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
        int k;
        resp = 2'h3;
        d = 32'h0;
        @(posedge mclk);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge mclk);
            if (arv && arr)
                arv <= 1'b0;
            if (rv)
            begin
                d = rd;
                resp = rr;
                rre <= 1'b0;
                break;
            end
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [1:0] r;
        bus_wr(a, d, r);
        chk(32'(r), `PA_RESP_OKAY, "bresp");
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e, input string msg);
        logic [31:0] v;
        logic [1:0] r;
        bus_rd(a, v, r);
        chk({22'h0, r, v[7:0] & m}, {24'h0, e}, msg);
    endtask
    task automatic pulse(input logic [3:0] n);
        int k;
        @(posedge mclk);
        start <= 1'b1;
        tog <= n;
        slw <= 4'($urandom % 8);
        @(posedge mclk);
        start <= 1'b0;
        for (k = 0; k < 300; k++)
        begin
            @(posedge mclk);
            if (!busy)
                break;
        end
    endtask
    task automatic wait_per(input int b);
        int k;
        for (k = 0; k < 1000; k++)
        begin
            @(posedge mclk);
            if (srcs[b] === 1'b1)
                break;
        end
    endtask
    // Counts selected edges in n level changes starting from level p0.
    function automatic int exp_edges(input logic p0, input int n, input logic sel);
        int c = 0;
        for (int i = 1; i <= n; i++)
            if ((p0 ^ i[0]) == sel)
                c++;
        return c;
    endfunction
    initial
    begin
        #500000;
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        int e, n, c0, k;
        logic [31:0] v;
        logic [1:0] r;
        logic p0;
        time t1;
        {rst, awv, wv, bre, arv, rre, start} = 7'b1000000;
        {awa, ara, wd, ws, tog, slw} = '0;
        void'($urandom(64));
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        chk({30'h0, ic4, oc5}, 32'h1, "steer reset");
        chk_rd(A_CTL, 8'hFF, 8'h00, "ctrl reset");
        chk_rd(A_FLG, 8'hBF, 8'h00, "flag reset");
        bus_wr(16'h40A0, 8'hFF, r);
        chk(32'(r), `PA_RESP_SLVERR, "unmapped");
        bus_rd(16'h4099, v, r);
        chk(32'(r), `PA_RESP_SLVERR, "misaligned");
        for (k = 0; k < 6; k++)
        begin
            v = (k == 0) ? 32'hBF : 32'($urandom) & 32'hBF;
            wr(A_CTL, v[7:0]);
            chk_rd(A_CTL, 8'hFF, v[7:0] & 8'h37, "ctrl");
            chk({30'h0, ic4, oc5}, {30'h0, v[2], ~v[2]}, "steer");
            wr(A_MSK, ~v[7:0]);
            chk_rd(A_MSK, 8'hFF, ~v[7:0] & 8'hF3, "masks");
            wr(A_CNT, v[7:0]);
            chk_rd(A_CNT, 8'hFF, v[7:0], "count");
        end
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        chk_rd(A_CNT, 8'hFF, v[7:0], "count kept");
        for (e = 0; e < 2; e++)
        begin
            wr(A_CTL, 8'h40 | 8'(e << 4));
            c0 = 248 + $urandom % 8;
            wr(A_CNT, 8'(c0));
            wr(A_MSK, 8'h30);
            wr(A_FLG, 8'hF0);
            p0 = pin;
            n = 1 + $urandom % 9;
            pulse(4'(n));
            k = c0 + exp_edges(p0, n, e[0]);
            chk_rd(A_CNT, 8'hFF, 8'(k), "event count");
            chk_rd(A_FLG, 8'h3F, {2'b0, k > 255, k > c0, 4'h0}, "event flags");
            chk(32'(srcs) & 32'h3, {30'h0, k > 255, k > c0}, "irq sources");
            wr(A_FLG, 8'h10);
            chk_rd(A_FLG, 8'h3F, {2'b0, k > 255, 5'h0}, "clear one");
            wr(A_FLG, 8'h20);
            chk_rd(A_FLG, 8'h30, 8'h00, "clear two");
        end
        wr(A_CTL, 8'h10);
        wr(A_CNT, 8'h5A);
        pulse(4'h4);
        chk_rd(A_CNT, 8'hFF, 8'h5A, "disabled hold");
        chk_rd(A_FLG, 8'h30, 8'h00, "disabled flags");
        for (e = 0; e < 2; e++)
        begin
            wr(A_CTL, 8'h60 | 8'(e << 4));
            if (pin !== e[0])
                pulse(4'h1);
            wr(A_CNT, 8'h00);
            repeat (200) @(posedge mclk);
            chk_rd(A_CNT, 8'hFF, 8'h00, "inhibited");
            pulse(4'h1);
            repeat (400) @(posedge mclk);
            pulse(4'h1);
            bus_rd(A_CNT, v, r);
            c0 = 400 / (EDIV * GDIV);
            chk(32'(v[7:0] >= c0 - 2 && v[7:0] <= c0 + 7), 1, "gated count");
        end
        wr(A_MSK, 8'h40);
        for (e = 0; e < 4; e++)
        begin
            wr(A_CTL, 8'(e));
            wait_per(2);
            wr(A_FLG, 8'h40);
            wait_per(2);
            t1 = $time;
            wr(A_FLG, 8'h40);
            wait_per(2);
            chk(32'(($time - t1) / 20), 32'(EDIV << (RTI + e)), "period");
            chk(32'(irq), 1, "periodic irq");
        end
        wr(A_MSK, 8'h80);
        wait_per(3);
        wr(A_FLG, 8'h80);
        wait_per(3);
        t1 = $time;
        wr(A_FLG, 8'h80);
        wait_per(3);
        chk(32'(($time - t1) / 20), 32'(EDIV << MW), "main wrap");
        chk(32'(irq), 1, "main irq");
        wr(A_MSK, 8'h00);
        wr(A_FLG, 8'hF0);
        repeat (300) @(posedge mclk);
        chk({27'h0, irq, srcs}, 0, "masked");
        chk_rd(A_FLG, 8'h40, 8'h40, "free running");
        tally_and_finish();
    end
endmodule
`default_nettype wire
